// *** twp_pkg.sv ***
package twp_pkg;

  // ----------------------------------------------------------------
  // Fabric word layout
  // ----------------------------------------------------------------
  localparam int unsigned FW_W      = 22;
  localparam int unsigned BYTE_W    = 8;
  localparam int unsigned SYM_W     = 10;
  localparam int unsigned LO_BYTE_L = 0;
  localparam int unsigned LO_CTRL   = 8;
  localparam int unsigned LO_FDISP  = 9;
  localparam int unsigned LO_DVAL   = 10;
  localparam int unsigned HI_BYTE_L = 11;
  localparam int unsigned HI_CTRL   = 19;
  localparam int unsigned HI_FDISP  = 20;
  localparam int unsigned HI_DVAL   = 21;
  localparam int unsigned HI_SYM_L  = 11;
  localparam int unsigned IDLE_LEAD_CYC = 10;

  // ----------------------------------------------------------------
  // Register map (AXI4-Lite byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL  = 8'h00;
  localparam logic [7:0] ADDR_STAT  = 8'h04;
  localparam logic [7:0] ADDR_LANE0 = 8'h08;
  localparam logic [7:0] ADDR_LANE1 = 8'h0C;
  localparam logic [1:0] RESP_OKAY  = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [2:0] CTRL_RST   = 3'h0;

  // Interface width selection
  typedef enum logic [1:0] {TWP_W8, TWP_W10, TWP_W16, TWP_W20} twp_width_t;

  // One lane as seen by the PCS
  typedef struct packed {
    logic [SYM_W-1:0] sym;     // Byte in low bits, or full 10-bit symbol
    logic             ctrl;
    logic             fdisp;
    logic             dval;
    logic             compl;
    logic             elec_idle;
  } twp_lane_t;

endpackage : twp_pkg

// *** twp_lane_unpack.sv ***
`timescale 1ns/1ps
// Splits one half of the fabric word into lane controls
module twp_lane_unpack
  import twp_pkg::*;
(
  input  wire logic [SYM_W:0] seg,
  input  wire logic           sym_mode,
  input  wire logic           use_8b10b,
  input  wire logic           pipe_mode,
  input  wire logic           fd_allow,
  output twp_lane_t           lane
);
  // ----------------------------------------------------------------
  // Field mapping
  // ----------------------------------------------------------------
  always_comb
  begin
    lane = '0;
    if (sym_mode)
    begin
      lane.sym = seg[SYM_W-1:0];
    end
    else
    begin
      lane.sym[BYTE_W-1:0] = seg[BYTE_W-1:0];
      lane.ctrl      = use_8b10b & seg[LO_CTRL];
      lane.fdisp     = ~pipe_mode & fd_allow & seg[LO_FDISP];
      lane.compl     = pipe_mode & fd_allow & seg[LO_FDISP];
      lane.dval      = ~pipe_mode & seg[LO_DVAL];
      lane.elec_idle = pipe_mode & seg[LO_DVAL];
    end
  end
endmodule : twp_lane_unpack

// *** twp_idle_timer.sv ***
`timescale 1ns/1ps
// Counts consecutive cycles of a level, saturating
module twp_idle_timer
  import twp_pkg::*;
#(
  parameter int unsigned LEAD = IDLE_LEAD_CYC
)
(
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic level,
  output logic      ready
);
  logic [7:0] cnt_reg;

  // ----------------------------------------------------------------
  // Saturating counter
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      cnt_reg <= 8'h00;
    else if (!level)
      cnt_reg <= 8'h00;
    else if (cnt_reg < 8'(LEAD))
      cnt_reg <= cnt_reg + 8'h01;
  end

  assign ready = (cnt_reg >= 8'(LEAD));
endmodule : twp_idle_timer

// *** twp_tx_word.sv ***
// Local design decisions: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
// ------------------------------------------------------------------
// Transmit fabric word unpacker with AXI4-Lite control
// ------------------------------------------------------------------
// Contract
// - 8-bit width: bits 7..0 carry the payload byte.
// - 8-bit width, 8B/10B: bit 8 marks a control character.
// - 8-bit: bit 9 forces disparity; in PIPE it forces compliance disparity.
// - 8-bit non-PIPE: bit 10 is the forced disparity value.
// - 8-bit PIPE: bit 10 forces electrical idle.
// - 10-bit width: bits 9..0 carry one encoded symbol.
// - 16-bit width: low byte bits 7..0, high byte bits 18..11.
// - 16-bit 8B/10B: bit 8 low control flag, bit 19 high flag.
// - 16-bit non-PIPE: bits 9 and 20 force disparity per byte.
// - 16-bit PIPE: bit 9 compliance force; bit 20 held zero.
// - 16-bit non-PIPE: bits 10 and 21 give disparity values.
// - 16-bit PIPE: bits 10 and 21 both force electrical idle.
// - 20-bit width: low symbol bits 9..0, high symbol 20..11.
module twp_tx_word
  import twp_pkg::*;
(
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [FW_W-1:0]  tx_word,
  input  wire logic             det_req,
  output twp_lane_t             lane0,
  output twp_lane_t             lane1,
  output logic                  lane1_valid,
  output logic                  det_go,
  input  wire logic [7:0]       s_axi_awaddr,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  output logic [1:0]            s_axi_bresp,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  input  wire logic [7:0]       s_axi_araddr,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready
);
  // ----------------------------------------------------------------
  // Control register: [1:0] width, [2] 8B/10B on, [3] PIPE mode
  // ----------------------------------------------------------------
  logic [3:0]       ctrl_reg;
  logic [FW_W-1:0]  word_reg;
  logic [7:0]       awaddr_reg;
  logic             aw_held_reg;
  logic [31:0]      wdata_reg;
  logic [3:0]       wstrb_reg;
  logic             w_held_reg;
  logic             pipe_viol_reg;
  twp_width_t       width;
  logic             use_8b10b;
  logic             pipe_mode;
  logic             sym_mode;
  logic             dual;
  logic             idle_any;
  logic             idle_ok;
  twp_lane_t        lane0_c;
  twp_lane_t        lane1_c;

  assign width     = twp_width_t'(ctrl_reg[1:0]);
  assign use_8b10b = ctrl_reg[2];
  assign pipe_mode = ctrl_reg[3];
  assign sym_mode  = (width == TWP_W10) || (width == TWP_W20);
  assign dual      = (width == TWP_W16) || (width == TWP_W20);

  // ----------------------------------------------------------------
  // Word sampling
  // ----------------------------------------------------------------
  // One capture per clock; lanes then come from flops
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      word_reg <= '0;
    else
      word_reg <= tx_word;
  end

  twp_lane_unpack u_lo (
    .seg       (word_reg[SYM_W:0]),
    .sym_mode  (sym_mode),
    .use_8b10b (use_8b10b),
    .pipe_mode (pipe_mode),
    .fd_allow  (1'b1),
    .lane      (lane0_c)
  );

  // High half forced-disparity is never honoured in PIPE mode
  twp_lane_unpack u_hi (
    .seg       (word_reg[FW_W-1:HI_SYM_L]),
    .sym_mode  (sym_mode),
    .use_8b10b (use_8b10b),
    .pipe_mode (pipe_mode),
    .fd_allow  (~pipe_mode),
    .lane      (lane1_c)
  );

  // Undefined bits of narrow widths never reach the high lane
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      lane0       <= '0;
      lane1       <= '0;
      lane1_valid <= 1'b0;
    end
    else
    begin
      lane0       <= lane0_c;
      lane1       <= dual ? lane1_c : '0;
      lane1_valid <= dual;
    end
  end

  // ----------------------------------------------------------------
  // Receiver detection gate
  // ----------------------------------------------------------------
  // Detection passes only after idle has been held long enough
  assign idle_any = pipe_mode && word_reg[LO_DVAL] && !sym_mode;
  twp_idle_timer u_idle (
    .aclk    (aclk),
    .aresetn (aresetn),
    .level   (idle_any),
    .ready   (idle_ok)
  );
  assign det_go = det_req && idle_ok;

  // Sticky flag: fabric drove bit 20 in 16-bit PIPE mode
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pipe_viol_reg <= 1'b0;
    else if (pipe_mode && width == TWP_W16 && word_reg[HI_FDISP])
      pipe_viol_reg <= 1'b1;
    else if (s_axi_bvalid && s_axi_bready && awaddr_reg == ADDR_STAT)
      pipe_viol_reg <= 1'b0;
  end

  // ----------------------------------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------------------------------
  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;

  // Address and data are taken in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      awaddr_reg  <= 8'h00;
      wdata_reg   <= 32'h0000_0000;
      wstrb_reg   <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        aw_held_reg <= 1'b0;
        w_held_reg  <= 1'b0;
      end
    end
  end

  // Commit and respond once both halves are held
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_reg     <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end
    else if (s_axi_bvalid)
    begin
      if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
    else if (aw_held_reg && w_held_reg)
    begin
      s_axi_bvalid <= 1'b1;
      if (awaddr_reg == ADDR_CTRL)
      begin
        if (wstrb_reg[0])
          ctrl_reg <= wdata_reg[3:0];
        s_axi_bresp <= RESP_OKAY;
      end
      else if (awaddr_reg == ADDR_STAT)
        s_axi_bresp <= RESP_OKAY;
      else
        s_axi_bresp <= RESP_SLVERR;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------------------------------
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end
    else if (s_axi_rvalid)
    begin
      if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
    else if (s_axi_arvalid)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= RESP_OKAY;
      if (s_axi_araddr == ADDR_CTRL)
        s_axi_rdata <= {28'h0000000, ctrl_reg};
      else if (s_axi_araddr == ADDR_STAT)
        s_axi_rdata <= {30'h00000000, idle_ok, pipe_viol_reg};
      else if (s_axi_araddr == ADDR_LANE0)
        s_axi_rdata <= {17'h00000, lane0};
      else if (s_axi_araddr == ADDR_LANE1)
        s_axi_rdata <= {17'h00000, lane1};
      else
      begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= RESP_SLVERR;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_byte8;
    @(posedge aclk) disable iff (!aresetn)
      (width == TWP_W8) ##1 (width == TWP_W8)
        |-> lane0.sym[BYTE_W-1:0] == $past(tx_word[BYTE_W-1:0], 2);
  endproperty
  a_byte8: assert property (p_byte8) else $error("low byte mismatch");

  property p_ctrl;
    @(posedge aclk) disable iff (!aresetn)
      (!sym_mode && use_8b10b && $stable(ctrl_reg))
        |=> lane0.ctrl == $past(word_reg[LO_CTRL]);
  endproperty
  a_ctrl: assert property (p_ctrl) else $error("control flag lost");

  property p_fdisp;
    @(posedge aclk) disable iff (!aresetn)
      (!sym_mode && !pipe_mode && $stable(ctrl_reg))
        |=> lane0.fdisp == $past(word_reg[LO_FDISP]) && !lane0.compl;
  endproperty
  a_fdisp: assert property (p_fdisp) else $error("force disparity wrong");

  property p_dval;
    @(posedge aclk) disable iff (!aresetn)
      (!sym_mode && !pipe_mode && $stable(ctrl_reg))
        |=> lane0.dval == $past(word_reg[LO_DVAL]) && !lane0.elec_idle;
  endproperty
  a_dval: assert property (p_dval) else $error("disparity value wrong");

  property p_idle;
    @(posedge aclk) disable iff (!aresetn)
      (!sym_mode && pipe_mode && $stable(ctrl_reg))
        |=> lane0.elec_idle == $past(word_reg[LO_DVAL]) && !lane0.dval;
  endproperty
  a_idle: assert property (p_idle) else $error("electrical idle wrong");

  property p_sym;
    @(posedge aclk) disable iff (!aresetn)
      (sym_mode && $stable(ctrl_reg))
        |=> lane0.sym == $past(word_reg[SYM_W-1:0]) && !lane0.ctrl;
  endproperty
  a_sym: assert property (p_sym) else $error("symbol mismatch");

  property p_hi;
    @(posedge aclk) disable iff (!aresetn)
      (width == TWP_W20 && $stable(ctrl_reg))
        |=> lane1.sym == $past(word_reg[FW_W-2:HI_SYM_L]) && lane1_valid;
  endproperty
  a_hi: assert property (p_hi) else $error("high symbol mismatch");

  property p_pipe_hi;
    @(posedge aclk) disable iff (!aresetn)
      pipe_mode |=> !lane1.fdisp && !lane1.compl;
  endproperty
  a_pipe_hi: assert property (p_pipe_hi) else $error("bit 20 honoured");

  property p_narrow;
    @(posedge aclk) disable iff (!aresetn)
      !dual |=> lane1 == '0 && !lane1_valid;
  endproperty
  a_narrow: assert property (p_narrow) else $error("undefined bits leak");

  property p_det;
    @(posedge aclk) disable iff (!aresetn)
      det_go |-> $past(idle_any) && $past(idle_any, IDLE_LEAD_CYC);
  endproperty
  a_det: assert property (p_det) else $error("detect before idle lead");

  c_w16: cover property (@(posedge aclk) width == TWP_W16 && lane1_valid);
  c_pipe_idle: cover property (@(posedge aclk) lane0.elec_idle && lane1.elec_idle);
  c_det: cover property (@(posedge aclk) det_go);
  c_wr: cover property (@(posedge aclk) s_axi_bvalid && s_axi_bready);

endmodule : twp_tx_word

// *** twp_fabric_model.sv ***
`timescale 1ns/1ps
// --------------------------------------------------------------
// Fabric-side user logic feeding the transmit word
// --------------------------------------------------------------
module twp_fabric_model
  import twp_pkg::*;
#(
  parameter int unsigned LEAD = IDLE_LEAD_CYC
)
(
  input  wire logic            aclk,
  input  wire logic            aresetn,
  input  wire logic [FW_W-1:0] cmd_word,
  input  wire logic            cmd_det,
  input  wire logic            pipe_on,
  input  wire logic            rude,
  output logic      [FW_W-1:0] tx_word,
  output logic                 det_req
);
  logic [7:0] idle_cnt_reg;

  // Word launch; bit 20 stays low in PIPE unless told to misbehave
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      tx_word <= '0;
    else if (pipe_on && !rude)
      tx_word <= cmd_word & ~(22'h1 << HI_FDISP);
    else
      tx_word <= cmd_word;
  end

  // Idle run length, saturating so a long idle never wraps
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !(pipe_on && tx_word[LO_DVAL]))
      idle_cnt_reg <= 8'h00;
    else if (idle_cnt_reg != 8'hFF)
      idle_cnt_reg <= idle_cnt_reg + 8'h01;
  end

  // Detect waits for the idle lead unless a scenario wants it early
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      det_req <= 1'b0;
    else
      det_req <= cmd_det && (rude || idle_cnt_reg >= LEAD);
  end
endmodule : twp_fabric_model

// *** test_twp_tx_word.sv ***
`timescale 1ns/1ps
module test_twp_tx_word;
  import twp_pkg::*;
  logic            aclk, aresetn, det_req, cmd_det, pipe_on, rude, lane1_valid, det_go;
  logic [FW_W-1:0] tx_word, cmd_word;
  twp_lane_t       lane0, lane1;
  logic [7:0]      s_axi_awaddr, s_axi_araddr;
  logic [31:0]     s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]      s_axi_wstrb;
  logic [1:0]      s_axi_bresp, s_axi_rresp, rs;
  logic            s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic            s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int              fails, compares;

  twp_fabric_model i_twp_fabric_model (.aclk(aclk), .aresetn(aresetn), .cmd_word(cmd_word),
    .cmd_det(cmd_det), .pipe_on(pipe_on), .rude(rude), .tx_word(tx_word), .det_req(det_req));
  twp_tx_word i_twp_tx_word (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .tx_word       (tx_word),
    .det_req       (det_req),
    .lane0         (lane0),
    .lane1         (lane1),
    .lane1_valid   (lane1_valid),
    .det_go        (det_go),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready)
  );

  // --------------------------------------------------------------
  // Clock, reset and watchdog
  // --------------------------------------------------------------
  initial
  begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  // Bound sized well above the roughly 160 cycles the tests need
  initial
  begin
    repeat (5000) @(posedge aclk);
    fails++;
    summarize();
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic summarize();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : summarize

  // --------------------------------------------------------------
  // AXI4-Lite master; ready is looked at mid-cycle, where it is settled
  // --------------------------------------------------------------
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_done, w_done, b_hit, a_h, w_h;
    int   n;
    aw_done = 0; w_done = 0; b_hit = 0; n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
    while (!b_hit && n < 100)
    begin
      @(negedge aclk);
      a_h = s_axi_awvalid && s_axi_awready;
      w_h = s_axi_wvalid && s_axi_wready;
      b_hit = aw_done && w_done && s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      if (a_h) begin s_axi_awvalid <= 1'b0; aw_done = 1; end
      if (w_h) begin s_axi_wvalid <= 1'b0; w_done = 1; end
      n++;
    end
    s_axi_bready <= 1'b0;
    chk("write done", {31'h0, b_hit}, 32'h1);
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_done, r_hit, a_h;
    int   n;
    ar_done = 0; r_hit = 0; n = 0;
    @(posedge aclk);
    s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
    while (!r_hit && n < 100)
    begin
      @(negedge aclk);
      a_h = s_axi_arvalid && s_axi_arready;
      r_hit = ar_done && s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (a_h) begin s_axi_arvalid <= 1'b0; ar_done = 1; end
      n++;
    end
    s_axi_rready <= 1'b0;
    chk("read done", {31'h0, r_hit}, 32'h1);
  endtask : axi_rd

  // Mode change, then a word held long enough to pass both stages
  task automatic mode(input logic [1:0] w, input logic enc, input logic pipe);
    axi_wr(ADDR_CTRL, {28'h0, pipe, enc, w}, rs);
    pipe_on <= pipe;
  endtask : mode

  task automatic send(input logic [FW_W-1:0] w);
    @(posedge aclk);
    cmd_word <= w;
    repeat (4) @(posedge aclk);
    @(negedge aclk);
  endtask : send

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic t_regs();
    axi_rd(ADDR_CTRL, rd, rs);
    chk("ctrl reset", rd[3:0], {1'b0, CTRL_RST});
    axi_rd(8'h10, rd, rs);
    chk("unmapped read resp", rs, RESP_SLVERR);
    axi_wr(8'h10, 32'hFFFFFFFF, rs);
    chk("unmapped write resp", rs, RESP_SLVERR);
    axi_wr(ADDR_CTRL, 32'h6, rs);
    chk("ctrl write resp", rs, RESP_OKAY);
    axi_rd(ADDR_CTRL, rd, rs);
    chk("ctrl readback", rd[3:0], 32'h6);
  endtask : t_regs

  task automatic t_w8();
    mode(TWP_W8, 1'b1, 1'b0);
    send(22'h3FF800 | 22'h0003A5);
    chk("w8 byte", lane0.sym, 32'hA5);
    chk("w8 ctrl", lane0.ctrl, 32'h1);
    chk("w8 fdisp", lane0.fdisp, 32'h1);
    chk("w8 dval", lane0.dval, 32'h0);
    chk("w8 lane1", lane1, 32'h0);
    chk("w8 lane1 valid", lane1_valid, 32'h0);
    send(22'h00043C);
    chk("w8 byte b", lane0.sym, 32'h3C);
    chk("w8 dval b", lane0.dval, 32'h1);
    chk("w8 fdisp b", lane0.fdisp, 32'h0);
    mode(TWP_W8, 1'b0, 1'b0);
    send(22'h000177);
    chk("w8 ctrl dropped", lane0.ctrl, 32'h0);
    mode(TWP_W8, 1'b1, 1'b1);
    send(22'h000611);
    chk("w8 pipe compl", lane0.compl, 32'h1);
    chk("w8 pipe idle", lane0.elec_idle, 32'h1);
  endtask : t_w8

  task automatic t_w10_w20();
    mode(TWP_W10, 1'b0, 1'b0);
    send(22'h3FF800 | 22'h0002B7);
    chk("w10 sym", lane0.sym, 32'h2B7);
    chk("w10 lane1 valid", lane1_valid, 32'h0);
    mode(TWP_W20, 1'b0, 1'b0);
    send((22'h15A << HI_SYM_L) | 22'h3A5);
    chk("w20 low sym", lane0.sym, 32'h3A5);
    chk("w20 high sym", lane1.sym, 32'h15A);
    chk("w20 lane1 valid", lane1_valid, 32'h1);
    // Snapshot registers must show the same lanes while the word is held
    axi_rd(ADDR_LANE0, rd, rs);
    chk("w20 lane0 reg", rd, 32'h0000_74A0);
    axi_rd(ADDR_LANE1, rd, rs);
    chk("w20 lane1 reg", rd, 32'h0000_2B40);
  endtask : t_w10_w20

  task automatic t_w16();
    mode(TWP_W16, 1'b1, 1'b0);
    send((22'hC3 << HI_BYTE_L) | (22'h1 << HI_FDISP) | 22'h55A);
    chk("w16 low byte", lane0.sym, 32'h5A);
    chk("w16 high byte", lane1.sym, 32'hC3);
    chk("w16 ctrl", {lane1.ctrl, lane0.ctrl}, 32'h1);
    chk("w16 fdisp", {lane1.fdisp, lane0.fdisp}, 32'h2);
    chk("w16 dval", {lane1.dval, lane0.dval}, 32'h1);
    send((22'h1 << HI_CTRL) | (22'h1 << HI_DVAL));
    chk("w16 ctrl hi", {lane1.ctrl, lane0.ctrl}, 32'h2);
    chk("w16 dval hi", {lane1.dval, lane0.dval}, 32'h2);
  endtask : t_w16

  task automatic t_w16_pipe();
    mode(TWP_W16, 1'b1, 1'b1);
    send((22'h1 << HI_DVAL) | 22'h600);
    chk("w16 pipe compl", lane0.compl, 32'h1);
    chk("w16 pipe idle", {lane1.elec_idle, lane0.elec_idle}, 32'h3);
    axi_rd(ADDR_STAT, rd, rs);
    chk("no bit20 violation", rd[0], 32'h0);
    rude <= 1'b1;
    send(22'h1 << HI_FDISP);
    rude <= 1'b0;
    send(22'h0);
    axi_rd(ADDR_STAT, rd, rs);
    chk("bit20 violation", rd[0], 32'h1);
    axi_wr(ADDR_STAT, 32'h1, rs);
    axi_rd(ADDR_STAT, rd, rs);
    chk("violation cleared", rd[0], 32'h0);
  endtask : t_w16_pipe

  // Early detect request must be held off until the idle lead is met
  task automatic t_detect();
    mode(TWP_W8, 1'b1, 1'b1);
    rude <= 1'b1;
    cmd_det <= 1'b1;
    send(22'h1 << LO_DVAL);
    chk("detect early", det_go, 32'h0);
    rude <= 1'b0;
    repeat (IDLE_LEAD_CYC + 4) @(posedge aclk);
    @(negedge aclk);
    chk("detect after lead", det_go, 32'h1);
    axi_rd(ADDR_STAT, rd, rs);
    chk("lead met flag", rd[1], 32'h1);
    cmd_det <= 1'b0;
    send(22'h0);
  endtask : t_detect

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial
  begin
    fails = 0; compares = 0; aresetn = 1'b0;
    cmd_word = '0; cmd_det = 1'b0; pipe_on = 1'b0; rude = 1'b0;
    s_axi_awaddr = 8'h00; s_axi_awvalid = 1'b0; s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'h0; s_axi_wvalid = 1'b0; s_axi_bready = 1'b0;
    s_axi_araddr = 8'h00; s_axi_arvalid = 1'b0; s_axi_rready = 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_w8();
    t_w10_w20();
    t_w16();
    t_w16_pipe();
    t_detect();
    summarize();
  end
endmodule : test_twp_tx_word
